// File: common/pdcg_pkg.sv
// Purpose: shared constants of the pulse-width generator group with capture
// Assumes: 32-bit register port, word-aligned byte addresses
// Notes: per-channel register blocks sit at base + 4 * channel
package pdcg_pkg;
  localparam int NUM_CH = 8;
  localparam int NUM_PAIR = 4;
  localparam int CNT_W = 16;
  localparam int PRE_W = 8;
  localparam int DZ_W = 8;
  localparam int DIV_W = 3;
  localparam int DCNT_W = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_PRESCALE = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_CLKDIV = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_PULSE_CTRL = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_DZ_TIME = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_RELOAD_BASE = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_CMP_BASE = 8'h30;
  localparam logic [ADDR_W-1:0] ADDR_CNT_BASE = 8'h50;
  localparam logic [ADDR_W-1:0] ADDR_RISE_BASE = 8'h70;
  localparam logic [ADDR_W-1:0] ADDR_FALL_BASE = 8'h90;
  localparam logic [ADDR_W-1:0] ADDR_CAPCTL_BASE = 8'hB0;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'hC0;
  localparam logic [ADDR_W-1:0] ADDR_CLEAR = 8'hC4;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_EN = 8'hC8;
  localparam logic [ADDR_W-1:0] BLOCK_SPAN = 8'h20;

  // field positions
  localparam int PCR_RUN_LSB = 0;
  localparam int PCR_AUTO_LSB = 8;
  localparam int PCR_DZEN_LSB = 16;
  localparam int CAP_RISE_IE_BIT = 1;
  localparam int CAP_FALL_IE_BIT = 2;
  localparam int CAP_EN_BIT = 3;
  localparam int CAP_CH_STRIDE = 16;
  localparam int STAT_CAP_LSB = 8;
  localparam int CLKDIV_STRIDE = 4;

  // divider select codes: value is log2 of the division
  localparam logic [DIV_W-1:0] DIV_SEL_MAX = 3'h4;
  localparam logic [DATA_W-1:0] RESET_WORD = 32'h0000_0000;
endpackage

// File: rtl/pdcg_deadzone.sv
// Purpose: dead-zone generator for one complementary pair
// Assumes: tick is the even channel's prescaled and divided timer tick
// Notes: both outputs stay low until the dead time after every source edge
`timescale 1ns/1ps
`default_nettype none
module pdcg_deadzone
  import pdcg_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // timing
  input wire logic tick,
  input wire logic [DZ_W-1:0] dz_time,
  // waveform
  input wire logic src,
  output logic out_a,
  output logic out_b
);
  logic src_q;
  logic [DZ_W-1:0] wait_cnt;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      src_q <= 1'b0;
      wait_cnt <= '0;
    end else if (ce) begin
      if (src != src_q) begin
        src_q <= src;
        wait_cnt <= dz_time;
      end else if (tick && wait_cnt != '0) begin
        wait_cnt <= wait_cnt - 1'b1;
      end
    end
  end

  assign out_a = src_q && (wait_cnt == '0);
  assign out_b = !src_q && (wait_cnt == '0);
endmodule
`default_nettype wire

// File: rtl/pdcg_channel.sv
// Purpose: one channel: period down-counter, compare, capture latches
// Assumes: cap_lvl is already synchronised to clk
// Notes: a rising edge of run loads the counter from the reload value
`timescale 1ns/1ps
`default_nettype none
module pdcg_channel
  import pdcg_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // control
  input wire logic tick,
  input wire logic run,
  input wire logic auto_reload,
  input wire logic reload_now,
  input wire logic cap_en,
  input wire logic [CNT_W-1:0] period_reload_value,
  input wire logic [CNT_W-1:0] cmp_value,
  input wire logic cap_lvl,
  // results
  output logic [CNT_W-1:0] count,
  output logic wave,
  output logic zero_pulse,
  output logic cap_rise,
  output logic cap_fall,
  output logic [CNT_W-1:0] rising_capture_latch,
  output logic [CNT_W-1:0] falling_capture_latch
);
  logic run_q;
  logic active;
  logic cap_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      run_q <= 1'b0;
      active <= 1'b0;
      count <= '0;
      wave <= 1'b0;
      zero_pulse <= 1'b0;
    end else if (ce) begin
      run_q <= run;
      zero_pulse <= 1'b0;
      if (!run) begin
        active <= 1'b0;
        wave <= 1'b0;
      end else if ((run && !run_q) || reload_now) begin
        active <= 1'b1;
        count <= period_reload_value;
        wave <= 1'b0;
      end else if (active && tick) begin
        if (count == '0) begin
          zero_pulse <= 1'b1;
          wave <= 1'b0;
          if (auto_reload) begin
            count <= period_reload_value;
          end else begin
            active <= 1'b0;
          end
        end else begin
          count <= count - 1'b1;
          if (count - 1'b1 == cmp_value) begin
            wave <= 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cap_q <= 1'b0;
      cap_rise <= 1'b0;
      cap_fall <= 1'b0;
      rising_capture_latch <= '0;
      falling_capture_latch <= '0;
    end else if (ce) begin
      cap_q <= cap_lvl;
      cap_rise <= cap_en && cap_lvl && !cap_q;
      cap_fall <= cap_en && !cap_lvl && cap_q;
      if (cap_en && cap_lvl && !cap_q) begin
        rising_capture_latch <= count;
      end
      if (cap_en && !cap_lvl && cap_q) begin
        falling_capture_latch <= count;
      end
    end
  end
endmodule
`default_nettype wire

// File: rtl/pdcg_top.sv
// Purpose: pulse-width generator group with dead zone and input capture
// Assumes: register master on clk; capture pins asynchronous to clk
// Notes: ce low freezes every flip-flop, register writes included
`timescale 1ns/1ps
`default_nettype none
module pdcg_top
  import pdcg_pkg::*;
#(
  parameter int CH_COUNT = NUM_CH,
  parameter int COUNTER_W = CNT_W
)(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [DATA_W-1:0] rd_data,
  // pins
  input wire logic [NUM_CH-1:0] cap_in,
  output logic [NUM_CH-1:0] pwm_out,
  output logic [NUM_CH-1:0] pwm_oe,
  // interrupt
  output logic irq
);
  if (CH_COUNT != NUM_CH || COUNTER_W != CNT_W) begin : g_param_check
    $error("pdcg_top: channel count and counter width are fixed");
  end

  // control registers
  logic [DATA_W-1:0] prescale;
  logic [DATA_W-1:0] clkdiv;
  logic [DATA_W-1:0] pulse_control_reg;
  logic [DATA_W-1:0] dz_time;
  logic [DATA_W-1:0] irq_en;
  logic [DATA_W-1:0] irq_indication_reg;
  logic [CNT_W-1:0] period_reload_value [NUM_CH];
  logic [CNT_W-1:0] cmp_value [NUM_CH];
  logic [DATA_W-1:0] capture_control [NUM_PAIR];

  // per-channel state seen by the register port
  logic [CNT_W-1:0] count [NUM_CH];
  logic [CNT_W-1:0] rising_latch_readback [NUM_CH];
  logic [CNT_W-1:0] falling_latch_readback [NUM_CH];
  logic [NUM_CH-1:0] wave;
  logic [NUM_CH-1:0] zero_pulse;
  logic [NUM_CH-1:0] cap_rise;
  logic [NUM_CH-1:0] cap_fall;
  logic [NUM_CH-1:0] cap_en;
  logic [NUM_CH-1:0] capture_irq_set;
  logic [NUM_CH-1:0] ch_tick;
  logic [NUM_CH-1:0] cap_meta;
  logic [NUM_CH-1:0] cap_sync;
  logic [NUM_PAIR-1:0] pre_tick;
  logic [NUM_PAIR-1:0] dz_a;
  logic [NUM_PAIR-1:0] dz_b;
  logic [NUM_CH-1:0] next_pin;
  logic [DATA_W-1:0] next_status;
  logic [DATA_W-1:0] clear_mask;
  logic [DATA_W-1:0] set_mask;
  logic [DATA_W-1:0] next_rd_data;

  function automatic logic in_block(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base);
    in_block = (a >= base) && (a < base + BLOCK_SPAN) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic [2:0] block_idx(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base);
    logic [ADDR_W-1:0] off;
    off = a - base;
    block_idx = off[4:2];
  endfunction

  // two-flop synchronisers for the capture pins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cap_meta <= '0;
      cap_sync <= '0;
    end else if (ce) begin
      cap_meta <= cap_in;
      cap_sync <= cap_meta;
    end
  end

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PAIR; gp++) begin : g_pre
      logic [PRE_W-1:0] pre_cnt;
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          pre_cnt <= '0;
          pre_tick[gp] <= 1'b0;
        end else if (ce) begin
          if (pre_cnt >= prescale[gp*PRE_W +: PRE_W]) begin
            pre_cnt <= '0;
            pre_tick[gp] <= 1'b1;
          end else begin
            pre_cnt <= pre_cnt + 1'b1;
            pre_tick[gp] <= 1'b0;
          end
        end
      end

      pdcg_deadzone u_dz (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .tick(ch_tick[2*gp]),
        .dz_time(dz_time[gp*DZ_W +: DZ_W]),
        .src(wave[2*gp]),
        .out_a(dz_a[gp]),
        .out_b(dz_b[gp])
      );
    end
  endgenerate

  genvar gc;
  generate
    for (gc = 0; gc < NUM_CH; gc++) begin : g_ch
      logic [DCNT_W-1:0] div_cnt;
      logic [DCNT_W-1:0] div_mask;
      logic [DIV_W-1:0] div_sel;
      assign div_sel = clkdiv[gc*CLKDIV_STRIDE +: DIV_W];
      assign div_mask = DCNT_W'((5'h01 << div_sel) - 5'h01);

      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          div_cnt <= '0;
          ch_tick[gc] <= 1'b0;
        end else if (ce) begin
          ch_tick[gc] <= 1'b0;
          if (pre_tick[gc/2]) begin
            div_cnt <= div_cnt + 1'b1;
            ch_tick[gc] <= ((div_cnt & div_mask) == div_mask);
          end
        end
      end

      assign cap_en[gc] = capture_control[gc/2][(gc%2)*CAP_CH_STRIDE + CAP_EN_BIT];
      assign capture_irq_set[gc] =
        (cap_rise[gc] && capture_control[gc/2][(gc%2)*CAP_CH_STRIDE + CAP_RISE_IE_BIT]) ||
        (cap_fall[gc] && capture_control[gc/2][(gc%2)*CAP_CH_STRIDE + CAP_FALL_IE_BIT]);

      pdcg_channel u_ch (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .tick(ch_tick[gc]),
        .run(pulse_control_reg[PCR_RUN_LSB + gc]),
        .auto_reload(pulse_control_reg[PCR_AUTO_LSB + gc]),
        .reload_now(capture_irq_set[gc]),
        .cap_en(cap_en[gc]),
        .period_reload_value(period_reload_value[gc]),
        .cmp_value(cmp_value[gc]),
        .cap_lvl(cap_sync[gc]),
        .count(count[gc]),
        .wave(wave[gc]),
        .zero_pulse(zero_pulse[gc]),
        .cap_rise(cap_rise[gc]),
        .cap_fall(cap_fall[gc]),
        .rising_capture_latch(rising_latch_readback[gc]),
        .falling_capture_latch(falling_latch_readback[gc])
      );

      // pairs from timers 0, 2, 4, 6
      always_comb begin
        if (pulse_control_reg[PCR_DZEN_LSB + gc/2]) begin
          next_pin[gc] = (gc % 2 == 0) ? dz_a[gc/2] : dz_b[gc/2];
        end else begin
          next_pin[gc] = wave[gc];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pwm_out <= '0;
      pwm_oe <= '0;
    end else if (ce) begin
      pwm_out <= next_pin & ~cap_en;
      pwm_oe <= ~cap_en;
    end
  end

  // register writes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prescale <= RESET_WORD;
      clkdiv <= RESET_WORD;
      pulse_control_reg <= RESET_WORD;
      dz_time <= RESET_WORD;
      irq_en <= RESET_WORD;
      for (int i = 0; i < NUM_CH; i++) begin
        period_reload_value[i] <= '0;
        cmp_value[i] <= '0;
      end
      for (int i = 0; i < NUM_PAIR; i++) begin
        capture_control[i] <= RESET_WORD;
      end
    end else if (ce && wr_en) begin
      if (addr == ADDR_PRESCALE) begin
        prescale <= wr_data;
      end
      if (addr == ADDR_CLKDIV) begin
        // codes above the largest division saturate to it
        for (int i = 0; i < NUM_CH; i++) begin
          clkdiv[i*CLKDIV_STRIDE +: CLKDIV_STRIDE] <= {1'b0,
            (wr_data[i*CLKDIV_STRIDE +: DIV_W] > DIV_SEL_MAX) ? DIV_SEL_MAX : wr_data[i*CLKDIV_STRIDE +: DIV_W]};
        end
      end
      if (addr == ADDR_PULSE_CTRL) begin
        pulse_control_reg <= wr_data;
      end
      if (addr == ADDR_DZ_TIME) begin
        dz_time <= wr_data;
      end
      if (addr == ADDR_IRQ_EN) begin
        irq_en <= wr_data;
      end
      if (in_block(addr, ADDR_RELOAD_BASE)) begin
        period_reload_value[block_idx(addr, ADDR_RELOAD_BASE)] <= wr_data[CNT_W-1:0];
      end
      if (in_block(addr, ADDR_CMP_BASE)) begin
        cmp_value[block_idx(addr, ADDR_CMP_BASE)] <= wr_data[CNT_W-1:0];
      end
      if (in_block(addr, ADDR_CAPCTL_BASE) && block_idx(addr, ADDR_CAPCTL_BASE) < 3'(NUM_PAIR)) begin
        capture_control[2'(block_idx(addr, ADDR_CAPCTL_BASE))] <= wr_data;
      end
    end
  end

  always_comb begin
    clear_mask = (wr_en && addr == ADDR_CLEAR) ? wr_data : RESET_WORD;
    set_mask = RESET_WORD;
    set_mask[NUM_CH-1:0] = zero_pulse;
    set_mask[STAT_CAP_LSB +: NUM_CH] = capture_irq_set;
    // a flag raised in the clearing cycle survives
    next_status = (irq_indication_reg & ~clear_mask) | set_mask;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_indication_reg <= RESET_WORD;
    end else if (ce) begin
      irq_indication_reg <= next_status;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(next_status & irq_en);
    end
  end

  // read mux, registered for next-cycle data
  always_comb begin
    next_rd_data = RESET_WORD;
    if (addr == ADDR_PRESCALE) begin
      next_rd_data = prescale;
    end else if (addr == ADDR_CLKDIV) begin
      next_rd_data = clkdiv;
    end else if (addr == ADDR_PULSE_CTRL) begin
      next_rd_data = pulse_control_reg;
    end else if (addr == ADDR_DZ_TIME) begin
      next_rd_data = dz_time;
    end else if (addr == ADDR_STATUS) begin
      next_rd_data = irq_indication_reg;
    end else if (addr == ADDR_IRQ_EN) begin
      next_rd_data = irq_en;
    end else if (in_block(addr, ADDR_RELOAD_BASE)) begin
      next_rd_data[CNT_W-1:0] = period_reload_value[block_idx(addr, ADDR_RELOAD_BASE)];
    end else if (in_block(addr, ADDR_CMP_BASE)) begin
      next_rd_data[CNT_W-1:0] = cmp_value[block_idx(addr, ADDR_CMP_BASE)];
    end else if (in_block(addr, ADDR_CNT_BASE)) begin
      next_rd_data[CNT_W-1:0] = count[block_idx(addr, ADDR_CNT_BASE)];
    end else if (in_block(addr, ADDR_RISE_BASE)) begin
      next_rd_data[CNT_W-1:0] = rising_latch_readback[block_idx(addr, ADDR_RISE_BASE)];
    end else if (in_block(addr, ADDR_FALL_BASE)) begin
      next_rd_data[CNT_W-1:0] = falling_latch_readback[block_idx(addr, ADDR_FALL_BASE)];
    end else if (in_block(addr, ADDR_CAPCTL_BASE) && block_idx(addr, ADDR_CAPCTL_BASE) < 3'(NUM_PAIR)) begin
      next_rd_data = capture_control[2'(block_idx(addr, ADDR_CAPCTL_BASE))];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= RESET_WORD;
    end else if (ce) begin
      rd_data <= rd_en ? next_rd_data : RESET_WORD;
    end
  end
endmodule
`default_nettype wire

// File: testbench/pdcg_top_sva.sv
// Purpose: port-level checker of the pulse-width group with capture
// Assumes: ce held high by the bench; writes decode as the register map says
// Notes: run and dead-zone bits are tracked from writes to pulse control
`timescale 1ns/1ps
`default_nettype none
module pdcg_top_sva
  import pdcg_pkg::*;
#(
  parameter int CH_COUNT = NUM_CH,
  parameter int COUNTER_W = CNT_W
)(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [DATA_W-1:0] rd_data,
  // pins
  input wire logic [NUM_CH-1:0] cap_in,
  input wire logic [NUM_CH-1:0] pwm_out,
  input wire logic [NUM_CH-1:0] pwm_oe,
  // interrupt
  input wire logic irq
);
  logic [NUM_CH-1:0] run_q;
  logic [NUM_PAIR-1:0] dz_q;
  logic [NUM_PAIR-1:0] pair_ov;
  logic cap_wr;
  logic rd_ok;
  assign cap_wr = ce && wr_en && addr[7:4] == 4'hB;
  assign rd_ok = ce && rd_en;
  assign pair_ov = {pwm_out[7] & pwm_out[6], pwm_out[5] & pwm_out[4], pwm_out[3] & pwm_out[2], pwm_out[1] & pwm_out[0]};

  function automatic logic div_ok(input logic [31:0] d);
    div_ok = 1'b1;
    for (int i = 0; i < 8; i++)
      if (d[4*i+:4] > 4'h4) div_ok = 1'b0;
  endfunction

  // mirror of run and pair-mode bits
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      run_q <= '0;
      dz_q <= '0;
    end else if (ce && wr_en && addr == ADDR_PULSE_CTRL) begin
      run_q <= wr_data[7:0];
      dz_q <= wr_data[19:16];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_count_read_width: assert property (rd_ok && addr[7:4] == 4'h5 |=> rd_data[31:16] == 16'h0000)
    else $error("counter read has upper bits set");
  a_latch_read_width: assert property (rd_ok && addr >= 8'h70 && addr < 8'hB0 |=> rd_data[31:16] == 16'h0000)
    else $error("latch read has upper bits set");
  a_div_code_limit: assert property (rd_ok && addr == ADDR_CLKDIV |=> div_ok(rd_data))
    else $error("divider code above divide by 16");
  a_status_flag_width: assert property (rd_ok && addr == ADDR_STATUS |=> rd_data[31:16] == 16'h0000)
    else $error("status read has upper bits set");
  a_irq_mask_off: assert property (ce && wr_en && addr == ADDR_IRQ_EN && wr_data == 32'h0 |=> ##[0:1] !irq)
    else $error("irq high with all enables off");
  a_pair_no_overlap: assert property ((dz_q & $past(dz_q, 4) & pair_ov) == 4'h0)
    else $error("both outputs of a pair high");
  a_stopped_low: assert property (!run_q[0] [*6] |-> !pwm_out[0])
    else $error("stopped channel output high");
  a_oe_cause: assert property ($changed(pwm_oe) && $past(rst_b, 3) |-> $past(cap_wr) || $past(cap_wr, 2))
    else $error("output enable moved without capture write");
  a_oe_after_reset: assert property ($rose(rst_b) |=> pwm_oe == 8'hFF && !irq)
    else $error("pins not driving after reset");
  a_input_quiet: assert property ((pwm_out & ~pwm_oe & ~$past(pwm_oe, 2)) == 8'h00)
    else $error("capture pin driven high");

  c_irq: cover property ($rose(irq));
  c_capture_on: cover property ($fell(pwm_oe[2]));
  c_odd_pair: cover property ($rose(pwm_out[1]));
endmodule

bind pdcg_top pdcg_top_sva #(.CH_COUNT(CH_COUNT), .COUNTER_W(COUNTER_W)) pdcg_top_sva_inst (.clk(clk),
  .rst_b(rst_b), .ce(ce), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
  .cap_in(cap_in), .pwm_out(pwm_out), .pwm_oe(pwm_oe), .irq(irq));
`default_nettype wire

// File: testbench/pdcg_far_side.sv
// Purpose: far side of the pins: capture sources and output loads
// Assumes: capture edges come from this model only
// Notes: loads record every high output and any overlap inside a pair
`timescale 1ns/1ps
`default_nettype none
module pdcg_far_side
  import pdcg_pkg::*;
(
  // control
  input wire logic clk,
  input wire logic clr,
  // pins
  input wire logic [NUM_CH-1:0] pwm_out,
  output logic [NUM_CH-1:0] cap_in,
  // observations
  output logic [NUM_CH-1:0] seen_high,
  output logic [NUM_PAIR-1:0] overlap
);
  initial cap_in = '0;

  task automatic set_cap(input int ch, input logic lvl);
    repeat (20) @(posedge clk);
    cap_in[ch] <= lvl;
  endtask

  always @(posedge clk) begin
    if (clr) begin
      seen_high <= '0;
      overlap <= '0;
    end else begin
      seen_high <= seen_high | pwm_out;
      for (int p = 0; p < NUM_PAIR; p++)
        overlap[p] <= overlap[p] | (pwm_out[2*p] & pwm_out[2*p+1]);
    end
  end
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
// Purpose: self-checking bench of the pulse-width group with capture
// Assumes: prescale 0 and divide code 0 give one tick per clock
// Notes: register rows first, then timer, pair, capture and reset cases
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import pdcg_pkg::*;
;
  typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e;} pdcg_row_t;
  logic clk, rst_b, ce, wr_en, rd_en, irq, clr;
  logic [7:0] addr, cap_in, pwm_out, pwm_oe, seen_high;
  logic [3:0] overlap;
  logic [31:0] wr_data, rd_data, v, c;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;
  pdcg_row_t rows [9] = '{
    '{ADDR_PULSE_CTRL, 1'b0, 32'h0, RESET_WORD},
    '{ADDR_STATUS, 1'b0, 32'h0, RESET_WORD},
    '{ADDR_PRESCALE, 1'b1, 32'h0403_0201, 32'h0403_0201},
    '{ADDR_CLKDIV, 1'b1, 32'h0000_0007, 32'h0000_0004},
    '{ADDR_CLKDIV, 1'b1, 32'h0000_0043, 32'h0000_0043},
    '{ADDR_RELOAD_BASE + 8'h1C, 1'b1, 32'hABCD_1234, 32'h0000_1234},
    '{ADDR_CNT_BASE, 1'b1, 32'h0000_FFFF, RESET_WORD},
    '{ADDR_CLEAR, 1'b1, 32'h0000_FFFF, RESET_WORD},
    '{8'hF0, 1'b1, 32'hFFFF_FFFF, RESET_WORD}};

  pdcg_top pdcg_top_inst (.clk(clk), .rst_b(rst_b), .ce(ce), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .cap_in(cap_in), .pwm_out(pwm_out), .pwm_oe(pwm_oe), .irq(irq));
  pdcg_far_side pdcg_far_side_inst (.clk(clk), .clr(clr), .pwm_out(pwm_out), .cap_in(cap_in),
    .seen_high(seen_high), .overlap(overlap));

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask

  task automatic poll(input int b, input logic lvl);
    logic [31:0] d;
    for (int i = 0; i < 300; i++) begin
      rd(ADDR_STATUS, d);
      if (d[b] === lvl) break;
    end
    check("status bit", 32'(d[b]), 32'(lvl));
  endtask

  task automatic pulse_clr;
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask

  task automatic results;
    if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      results;
    end
  end

  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    wr_en = 1'b0;
    rd_en = 1'b0;
    clr = 1'b0;
    addr = 8'h00;
    wr_data = 32'h0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rd(rows[i].a, v);
      check("register", v, rows[i].e); // table values
    end
    wr(ADDR_PRESCALE, 32'h0);
    wr(ADDR_CLKDIV, 32'h0);
    wr(ADDR_DZ_TIME, 32'h0202_0202);
    wr(ADDR_RELOAD_BASE, 32'h0000_0028);
    wr(ADDR_CMP_BASE, 32'h0000_000A);
    wr(ADDR_IRQ_EN, 32'h0000_0001);
    pulse_clr;
    wr(ADDR_PULSE_CTRL, 32'h0000_0101);
    poll(0, 1'b1); // flag at zero
    check("irq", 32'(irq), 32'h1); // enabled flag
    wr(ADDR_CLEAR, 32'h1);
    rd(ADDR_STATUS, v);
    check("flag cleared", v & 32'h1, 32'h0); // clear works
    poll(0, 1'b1); // reload repeats
    check("wave high", 32'(seen_high[0]), 32'h1); // compare match
    wr(ADDR_IRQ_EN, 32'h0);
    @(posedge clk);
    #1 check("masked irq", 32'(irq), 32'h0); // masked
    wr(ADDR_RELOAD_BASE + 8'h04, 32'h0000_0005);
    wr(ADDR_PULSE_CTRL, 32'h0000_0002);
    poll(1, 1'b1); // one-shot flag
    wr(ADDR_CLEAR, 32'h0000_0002);
    repeat (40) @(posedge clk);
    rd(ADDR_STATUS, v);
    check("single flag", v & 32'h2, 32'h0); // no second flag
    rd(ADDR_CNT_BASE + 8'h04, v);
    check("halted count", v, 32'h0); // halted at zero
    // prescale 1 and divide by 2 give one tick every four clocks
    wr(ADDR_PRESCALE, 32'h0000_0001);
    wr(ADDR_CLKDIV, 32'h0000_0010);
    wr(ADDR_PULSE_CTRL, 32'h0);
    wr(ADDR_PULSE_CTRL, 32'h0000_0002);
    repeat (12) @(posedge clk);
    rd(ADDR_STATUS, v);
    check("slow tick", v & 32'h2, 32'h0); // timer slowed
    poll(1, 1'b1); // slowed timer still ends
    wr(ADDR_PRESCALE, 32'h0);
    wr(ADDR_CLKDIV, 32'h0);
    for (int p = 0; p < 4; p++) begin
      wr(ADDR_PULSE_CTRL, 32'h0);
      wr(ADDR_RELOAD_BASE + 8'(8 * p), 32'h0000_0014);
      wr(ADDR_CMP_BASE + 8'(8 * p), 32'h0000_0008);
      pulse_clr;
      wr(ADDR_PULSE_CTRL, (32'h101 << (2 * p)) | (32'h1_0000 << p));
      repeat (100) @(posedge clk);
      check("pair outputs", 32'(seen_high >> (2 * p)) & 32'h3, 32'h3); // both from even timer
      check("pair overlap", 32'(overlap[p]), 32'h0); // dead time kept
    end
    wr(ADDR_PULSE_CTRL, 32'h0);
    wr(ADDR_RELOAD_BASE + 8'h08, 32'h0000_00C8);
    wr(ADDR_RELOAD_BASE + 8'h0C, 32'h0000_00C8);
    wr(ADDR_PULSE_CTRL, 32'h0000_0C0C);
    wr(ADDR_CAPCTL_BASE + 8'h04, 32'h000C_000A);
    wr(ADDR_IRQ_EN, 32'h0000_0C00);
    wr(ADDR_CLEAR, 32'h0000_FFFF);
    check("pin direction", 32'(pwm_oe[3:2]), 32'h0); // pins become inputs
    pdcg_far_side_inst.set_cap(2, 1'b1);
    poll(10, 1'b1); // rise flag
    check("capture irq", 32'(irq), 32'h1); // enabled rise
    rd(ADDR_RISE_BASE + 8'h08, v);
    rd(ADDR_CNT_BASE + 8'h08, c);
    check("reload on capture", 32'(c > v), 32'h1); // counter restarted
    wr(ADDR_CLEAR, 32'h0000_0400);
    pdcg_far_side_inst.set_cap(2, 1'b0);
    repeat (8) @(posedge clk);
    rd(ADDR_STATUS, v);
    check("fall not enabled", v & 32'h400, 32'h0); // fall enable off
    rd(ADDR_FALL_BASE + 8'h08, v);
    check("fall latch", 32'(v != 0 && v <= 32'hC8), 32'h1); // falling latch
    pdcg_far_side_inst.set_cap(3, 1'b1);
    repeat (8) @(posedge clk);
    rd(ADDR_STATUS, v);
    check("rise not enabled", v & 32'h800, 32'h0); // rise enable off
    pdcg_far_side_inst.set_cap(3, 1'b0);
    poll(11, 1'b1); // odd channel fall flag
    rst_b <= 1'b0;
    @(posedge clk);
    #1 check("reset outputs", 32'({pwm_out, pwm_oe, irq}), 32'h0); // quiet in reset
    @(posedge clk);
    rst_b <= 1'b1;
    rd(ADDR_CMP_BASE, v);
    check("compare after reset", v, RESET_WORD); // cleared
    check("pins after reset", 32'(pwm_oe), 32'h0000_00FF); // outputs again
    results;
  end
endmodule
`default_nettype wire
